// ===== rtl/ehc_defines.svh
`ifndef EHC_DEFINES_SVH
`define EHC_DEFINES_SVH

// ----------------------------------------
// Health test and conditioner sizes and cutoffs
// ----------------------------------------
`define EHC_WINDOW_LEN 1024
`define EHC_FLUSH_MAX 1024
`define EHC_REP_CUTOFF 32
`define EHC_WIN_CUTOFF 840
`define EHC_FATAL_ALARMS 4
`define EHC_SELF_TEST_CYCLES 64
`define EHC_XOR_GROUP 4

`endif

// ===== rtl/ehc_entropy_health_conditioner.sv
`timescale 1ns/1ps
`include "ehc_defines.svh"
module ehc_entropy_health_conditioner #(
	parameter int WINDOW_LEN = `EHC_WINDOW_LEN,
	parameter int REP_CUTOFF = `EHC_REP_CUTOFF,
	parameter int WIN_CUTOFF = `EHC_WIN_CUTOFF,
	parameter int FATAL_ALARMS = `EHC_FATAL_ALARMS,
	parameter int SELF_TEST_CYCLES = `EHC_SELF_TEST_CYCLES,
	parameter int XOR_GROUP = `EHC_XOR_GROUP
) (
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic raw_valid,
	input wire logic raw_bit,
	input wire ehc_pkg::ehc_cond_t cond_mode,
	output logic out_valid,
	output logic out_bit,
	output ehc_pkg::ehc_state_t es_state,
	output logic alarm_pulse
);

	localparam int CW = $clog2(WINDOW_LEN + 1);
	localparam int TW = $clog2(SELF_TEST_CYCLES + 1);
	localparam int AW = $clog2(FATAL_ALARMS + 1);
	localparam int GW = $clog2(XOR_GROUP + 1);

	// ----------------------------------------
	// Health counters
	// ----------------------------------------
	logic prev_r, prev_nxt;
	logic have_prev_r, have_prev_nxt;
	logic [CW-1:0] rep_cnt_r, rep_cnt_nxt;
	logic [CW-1:0] samp_cnt_r, samp_cnt_nxt;
	logic [CW-1:0] win_cnt_r, win_cnt_nxt;
	logic ref_r, ref_nxt;
	logic ref_ok_r, ref_ok_nxt;
	logic rep_hit, win_hit;

	always_comb begin
		prev_nxt = prev_r;
		have_prev_nxt = have_prev_r;
		rep_cnt_nxt = rep_cnt_r;
		samp_cnt_nxt = samp_cnt_r;
		win_cnt_nxt = win_cnt_r;
		ref_nxt = ref_r;
		ref_ok_nxt = ref_ok_r;
		rep_hit = 1'b0;
		win_hit = 1'b0;
		if (raw_valid && es_state != ehc_pkg::EHC_ST_FATAL) begin
			prev_nxt = raw_bit;
			have_prev_nxt = 1'b1;
			if (!have_prev_r || raw_bit != prev_r) begin
				rep_cnt_nxt = CW'(1);
			end else if (rep_cnt_r + CW'(1) >= CW'(REP_CUTOFF)) begin
				rep_hit = 1'b1;
				rep_cnt_nxt = CW'(1);
			end else begin
				rep_cnt_nxt = rep_cnt_r + CW'(1);
			end
			if (samp_cnt_r == CW'(0)) begin
				ref_nxt = raw_bit;
				ref_ok_nxt = 1'b1;
				win_cnt_nxt = CW'(0);
				samp_cnt_nxt = CW'(1);
			end else begin
				if (ref_ok_r && raw_bit == ref_r) begin
					if (win_cnt_r + CW'(1) > CW'(WIN_CUTOFF)) begin
						win_hit = 1'b1;
					end
					win_cnt_nxt = win_cnt_r + CW'(1);
				end
				// Window wraps to restart state: flushed
				samp_cnt_nxt = (samp_cnt_r == CW'(WINDOW_LEN - 1)) ? CW'(0) : samp_cnt_r + CW'(1);
				if (win_hit) begin
					win_cnt_nxt = CW'(0);
					samp_cnt_nxt = CW'(0);
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_r <= 1'b0;
			have_prev_r <= 1'b0;
			rep_cnt_r <= '0;
			samp_cnt_r <= '0;
			win_cnt_r <= '0;
			ref_r <= 1'b0;
			ref_ok_r <= 1'b0;
		end else if (clk_en) begin
			prev_r <= prev_nxt;
			have_prev_r <= have_prev_nxt;
			rep_cnt_r <= rep_cnt_nxt;
			samp_cnt_r <= samp_cnt_nxt;
			win_cnt_r <= win_cnt_nxt;
			ref_r <= ref_nxt;
			ref_ok_r <= ref_ok_nxt;
		end
	end

	// ----------------------------------------
	// Source state machine
	// ----------------------------------------
	ehc_pkg::ehc_state_t state_nxt;
	logic [TW-1:0] st_cnt_r, st_cnt_nxt;
	logic [AW-1:0] alarm_cnt_r, alarm_cnt_nxt;
	logic alarm_nxt;
	logic any_hit;

	always_comb begin
		state_nxt = es_state;
		st_cnt_nxt = st_cnt_r;
		alarm_cnt_nxt = alarm_cnt_r;
		any_hit = rep_hit | win_hit;
		alarm_nxt = any_hit;
		case (es_state)
			ehc_pkg::EHC_ST_SELF_TEST: begin
				if (any_hit && alarm_cnt_r + AW'(1) >= AW'(FATAL_ALARMS)) begin
					state_nxt = ehc_pkg::EHC_ST_FATAL;
				end else if (any_hit) begin
					alarm_cnt_nxt = alarm_cnt_r + AW'(1);
					st_cnt_nxt = TW'(0);
				end else if (st_cnt_r == TW'(SELF_TEST_CYCLES - 1)) begin
					state_nxt = ehc_pkg::EHC_ST_NO_DATA;
					st_cnt_nxt = TW'(0);
				end else begin
					st_cnt_nxt = st_cnt_r + TW'(1);
				end
			end
			ehc_pkg::EHC_ST_NO_DATA, ehc_pkg::EHC_ST_ENTROPY_VALID: begin
				if (any_hit && alarm_cnt_r + AW'(1) >= AW'(FATAL_ALARMS)) begin
					state_nxt = ehc_pkg::EHC_ST_FATAL;
				end else if (any_hit) begin
					state_nxt = ehc_pkg::EHC_ST_SELF_TEST;
					alarm_cnt_nxt = alarm_cnt_r + AW'(1);
					st_cnt_nxt = TW'(0);
				end else if (out_valid) begin
					state_nxt = ehc_pkg::EHC_ST_ENTROPY_VALID;
				end
			end
			default: begin
				state_nxt = ehc_pkg::EHC_ST_FATAL;
				alarm_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			es_state <= ehc_pkg::EHC_ST_SELF_TEST;
			st_cnt_r <= '0;
			alarm_cnt_r <= '0;
			alarm_pulse <= 1'b0;
		end else if (clk_en) begin
			es_state <= state_nxt;
			st_cnt_r <= st_cnt_nxt;
			alarm_cnt_r <= alarm_cnt_nxt;
			alarm_pulse <= alarm_nxt;
		end
	end

	// ----------------------------------------
	// Non-cryptographic conditioner
	// ----------------------------------------
	logic acc_r, acc_nxt;
	logic [GW-1:0] grp_r, grp_nxt;
	logic ov_nxt, ob_nxt;
	logic live;

	always_comb begin
		acc_nxt = acc_r;
		grp_nxt = grp_r;
		ov_nxt = 1'b0;
		ob_nxt = out_bit;
		live = (es_state == ehc_pkg::EHC_ST_NO_DATA) || (es_state == ehc_pkg::EHC_ST_ENTROPY_VALID);
		if (raw_valid && live && !rep_hit && !win_hit) begin
			case (cond_mode)
				ehc_pkg::EHC_COND_XOR: begin
					if (grp_r == GW'(XOR_GROUP - 1)) begin
						ov_nxt = 1'b1;
						ob_nxt = acc_r ^ raw_bit;
						acc_nxt = 1'b0;
						grp_nxt = GW'(0);
					end else begin
						acc_nxt = acc_r ^ raw_bit;
						grp_nxt = grp_r + GW'(1);
					end
				end
				ehc_pkg::EHC_COND_PAIR: begin
					if (grp_r == GW'(1)) begin
						ov_nxt = (acc_r != raw_bit);
						ob_nxt = (acc_r != raw_bit) ? acc_r : out_bit;
						grp_nxt = GW'(0);
					end else begin
						acc_nxt = raw_bit;
						grp_nxt = GW'(1);
					end
				end
				default: begin
					ov_nxt = 1'b1;
					ob_nxt = raw_bit;
				end
			endcase
		end else if (!live) begin
			acc_nxt = 1'b0;
			grp_nxt = GW'(0);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			acc_r <= 1'b0;
			grp_r <= '0;
			out_valid <= 1'b0;
			out_bit <= 1'b0;
		end else if (clk_en) begin
			acc_r <= acc_nxt;
			grp_r <= grp_nxt;
			out_valid <= ov_nxt;
			out_bit <= ob_nxt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_fatal_sticky;
		@(posedge ref_clk) disable iff (!rst_b) es_state == ehc_pkg::EHC_ST_FATAL |=> es_state == ehc_pkg::EHC_ST_FATAL;
	endproperty
	a_fatal_sticky: assert property (p_fatal_sticky) else $error("fatal state left");
	property p_no_out_fatal;
		@(posedge ref_clk) disable iff (!rst_b) es_state == ehc_pkg::EHC_ST_FATAL |=> !out_valid;
	endproperty
	a_no_out_fatal: assert property (p_no_out_fatal) else $error("output in fatal state");
	property p_selftest_temporary;
		@(posedge ref_clk) disable iff (!rst_b)
			clk_en && $rose(es_state == ehc_pkg::EHC_ST_SELF_TEST) ##1 (clk_en && !alarm_pulse)[*8]
			|-> ##[0:80] es_state != ehc_pkg::EHC_ST_SELF_TEST;
	endproperty
	a_selftest_temporary: assert property (p_selftest_temporary) else $error("self-test did not end");

	property p_alarm_to_selftest;
		@(posedge ref_clk) disable iff (!rst_b)
			clk_en && alarm_pulse && $past(es_state) != ehc_pkg::EHC_ST_SELF_TEST && $past(clk_en)
			|-> es_state == ehc_pkg::EHC_ST_SELF_TEST || es_state == ehc_pkg::EHC_ST_FATAL;
	endproperty
	a_alarm_to_selftest: assert property (p_alarm_to_selftest) else $error("alarm left state live");

	property p_counters_hold;
		@(posedge ref_clk) disable iff (!rst_b) !raw_valid || !clk_en |=> $stable(samp_cnt_r) && $stable(rep_cnt_r);
	endproperty
	a_counters_hold: assert property (p_counters_hold) else $error("counter moved without sample");

	property p_window_bound;
		@(posedge ref_clk) disable iff (!rst_b) samp_cnt_r < CW'(WINDOW_LEN) && rep_cnt_r <= CW'(REP_CUTOFF);
	endproperty
	a_window_bound: assert property (p_window_bound) else $error("counter beyond window");

	property p_pair_drop;
		@(posedge ref_clk) disable iff (!rst_b)
			clk_en && cond_mode == ehc_pkg::EHC_COND_PAIR && ov_nxt |-> acc_r != raw_bit && ob_nxt == acc_r;
	endproperty
	a_pair_drop: assert property (p_pair_drop) else $error("pair extractor wrong");

	property p_valid_only_live;
		@(posedge ref_clk) disable iff (!rst_b) out_valid && $past(clk_en) |-> $past(live) && $past(raw_valid);
	endproperty
	a_valid_only_live: assert property (p_valid_only_live) else $error("spurious output strobe");

	property p_reset_clear;
		@(posedge ref_clk) $rose(rst_b) |-> rep_cnt_r == '0 && win_cnt_r == '0 && samp_cnt_r == '0;
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("counters not cleared");

	c_fatal: cover property (@(posedge ref_clk) disable iff (!rst_b) es_state == ehc_pkg::EHC_ST_FATAL);
	c_valid: cover property (@(posedge ref_clk) disable iff (!rst_b) es_state == ehc_pkg::EHC_ST_ENTROPY_VALID);
	c_pair: cover property (@(posedge ref_clk) disable iff (!rst_b) out_valid && cond_mode == ehc_pkg::EHC_COND_PAIR);
	c_win: cover property (@(posedge ref_clk) disable iff (!rst_b) clk_en && win_hit);
endmodule

// ===== rtl/ehc_pkg.sv
package ehc_pkg;

	typedef enum logic [1:0] {
		EHC_ST_SELF_TEST,
		EHC_ST_NO_DATA,
		EHC_ST_ENTROPY_VALID,
		EHC_ST_FATAL
	} ehc_state_t;

	typedef enum logic [1:0] {
		EHC_COND_RAW,
		EHC_COND_XOR,
		EHC_COND_PAIR
	} ehc_cond_t;

endpackage

// ===== tb/ehc_noise_src.sv
`timescale 1ns/1ps
// ----------------
// Noise source model
// ----------------
module ehc_noise_src (
	input wire logic ref_clk,
	output logic raw_valid,
	output logic raw_bit
);
	logic last_bit = 1'b0;
	initial raw_valid = 1'b0;
	initial raw_bit = 1'b0;
	// Idle line shows inverse of last bit
	task automatic drive(input logic v, input logic b);
		@(posedge ref_clk);
		raw_valid <= v;
		raw_bit <= v ? b : ~last_bit;
		if (v)
			last_bit = b;
	endtask
endmodule

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
	localparam int ST_CYC = 4;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b0;
	ehc_pkg::ehc_cond_t cond_mode = ehc_pkg::EHC_COND_RAW;
	logic raw_valid, raw_bit, out_valid, out_bit, alarm_pulse;
	ehc_pkg::ehc_state_t es_state;
	int bad_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	int n = 0;
	int run = 0;
	logic acc = 1'b0;
	logic prev = 1'b0;
	logic live = 1'b0;
	logic en_last = 1'b0;
	int got = 0;
	logic exp_q[$];
	ehc_noise_src src_u (.ref_clk(ref_clk), .raw_valid(raw_valid), .raw_bit(raw_bit));
	ehc_entropy_health_conditioner #(.WINDOW_LEN(16), .REP_CUTOFF(4), .WIN_CUTOFF(10), .FATAL_ALARMS(4),
		.SELF_TEST_CYCLES(ST_CYC), .XOR_GROUP(4)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
		.raw_valid(raw_valid), .raw_bit(raw_bit), .cond_mode(cond_mode), .out_valid(out_valid),
		.out_bit(out_bit), .es_state(es_state), .alarm_pulse(alarm_pulse));
	initial forever #10 ref_clk = ~ref_clk;
	// ----------------
	// Checking
	// ----------------
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [1:0] seen, input logic [1:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	always @(negedge ref_clk) begin
		if (rst_b === 1'b1 && en_last === 1'b1 && out_valid === 1'b1) begin
			got++;
			if (exp_q.size() == 0)
				check("extra_bit", 2'h1, 2'h0);
			else
				check("out_bit", out_bit, exp_q.pop_front());
		end
	end
	always @(posedge ref_clk) begin
		en_last <= clk_en;
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			give_verdict();
		end
	end
	// ----------------
	// Stimulus and model
	// ----------------
	task automatic cond_bit(input logic b);
		case (cond_mode)
			ehc_pkg::EHC_COND_RAW: exp_q.push_back(b);
			ehc_pkg::EHC_COND_XOR: begin
				acc ^= b;
				n++;
				if (n == 4) begin
					exp_q.push_back(acc);
					acc = 1'b0;
					n = 0;
				end
			end
			default: begin
				if (n == 1 && acc != b)
					exp_q.push_back(acc);
				acc = b;
				n = 1 - n;
			end
		endcase
	endtask
	task automatic step(input logic v, input logic b, input logic en);
		src_u.drive(v, b);
		clk_en <= en;
		if (v && en) begin
			if (live)
				cond_bit(b);
			run = (b == prev) ? run + 1 : 1;
			prev = b;
		end
	endtask
	task automatic stream(input int k);
		logic b;
		for (int i = 0; i < k; i++) begin
			b = 1'($urandom % 2);
			if (run >= 2 && b == prev)
				b = ~b;
			step($urandom % 4 != 0, b, $urandom % 5 != 0);
		end
	endtask
	task automatic wait_live;
		for (int i = 0; i < ST_CYC + 4; i++) begin
			@(negedge ref_clk);
			if (es_state === ehc_pkg::EHC_ST_NO_DATA)
				break;
		end
		check("live_state", es_state, ehc_pkg::EHC_ST_NO_DATA);
	endtask
	task automatic do_reset(input ehc_pkg::ehc_cond_t m);
		step(1'b0, 1'b0, 1'b1);
		rst_b <= 1'b0;
		cond_mode <= m;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk);
		check("reset_state", es_state, ehc_pkg::EHC_ST_SELF_TEST);
		check("reset_out", {alarm_pulse, out_valid}, 2'h0);
		exp_q.delete();
		got = 0;
		n = 0;
		acc = 1'b0;
		run = 0;
		live = 1'b1;
		@(posedge ref_clk);
		rst_b <= 1'b1;
		wait_live();
	endtask
	task automatic alarm(input int k, input bit win);
		logic x;
		x = ~prev;
		for (int i = 1; i < (win ? 15 : 4); i++)
			step(1'b1, (i % 4 != 0) ? x : ~x, 1'b1);
		live = 1'b0;
		step(1'b1, x, 1'b1);
		step(1'b0, 1'b0, 1'b1);
		@(negedge ref_clk);
		if (win)
			check("win_alarm", alarm_pulse, 2'h1);
		else
			check("alarm", alarm_pulse, 2'h1);
		check("alarm_state", es_state, k < 4 ? ehc_pkg::EHC_ST_SELF_TEST : ehc_pkg::EHC_ST_FATAL);
		n = 0;
		acc = 1'b0;
		@(negedge ref_clk);
		check("alarm_len", alarm_pulse, 2'h0);
		if (k < 4) begin
			wait_live();
			live = 1'b1;
		end
	endtask
	initial begin
		n = $urandom(74772);
		for (int m = 0; m < 3; m++) begin
			do_reset(ehc_pkg::ehc_cond_t'(m));
			stream(48);
			repeat (3) step(1'b0, 1'b0, 1'b1);
			@(negedge ref_clk);
			check("valid_state", es_state, ehc_pkg::EHC_ST_ENTROPY_VALID);
			check("pending", exp_q.size() == 0, 2'h1);
			check("key_bits", 2'(got >= 2), 2'h1);
		end
		do_reset(ehc_pkg::EHC_COND_RAW);
		stream(10);
		for (int k = 1; k <= 4; k++) begin
			alarm(k, 1'b0);
			stream(10);
		end
		@(negedge ref_clk);
		check("fatal_hold", es_state, ehc_pkg::EHC_ST_FATAL);
		do_reset(ehc_pkg::EHC_COND_PAIR);
		alarm(1, 1'b1);
		stream(30);
		repeat (3) step(1'b0, 1'b0, 1'b1);
		@(negedge ref_clk);
		check("pending", exp_q.size() == 0, 2'h1);
		give_verdict();
	end
endmodule
